// ---- oswb_bridge.sv ----
// serial to single-wire bridge: command interpreter, slot engine, apb registers
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
//
// Functional notes
// - code 29 selects 512 us program pulse, answered by byte 28.
// - code 39 selects 524 ms strong pullup, answered by byte 38.
// - when armed by EF, each data byte is followed by pullup then pulse response.
// - baud codes 100 to 111 invert serial receive and transmit polarity.
// - active pullup drives rising edges until the line passes the trip level or APU_MAX_CYC cycles pass.
// - infinite pullup ends on F1 at once, then a pulse response is sent.
// - up to nine host bytes are buffered while the previous one is on the bus.
module oswb_bridge
	import oswb_pkg::*;
#(
	parameter int unsigned RST_LOW_P    = oswb_pkg::RST_LOW_CYC,
	parameter int unsigned RST_SAMPLE_P = oswb_pkg::RST_SAMPLE_CYC,
	parameter int unsigned RST_END_P    = oswb_pkg::RST_END_CYC,
	parameter int unsigned PP_P         = oswb_pkg::PP_CYC,
	parameter int unsigned SPU_P        = oswb_pkg::SPU_CYC
) (
	input  wire logic                   sys_clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   apb_psel_i,
	input  wire logic                   apb_penable_i,
	input  wire logic                   apb_pwrite_i,
	input  wire logic [oswb_pkg::APB_AW-1:0] apb_paddr_i,
	input  wire logic [31:0]            apb_pwdata_i,
	output logic      [31:0]            apb_prdata_o,
	output logic                        apb_pready_o,
	output logic                        apb_pslverr_o,
	input  wire logic                   host_rx_valid_i,
	input  wire logic [7:0]             host_rx_data_i,
	output logic                        host_rx_ready_o,
	output logic                        host_tx_valid_o,
	output logic      [7:0]             host_tx_data_o,
	input  wire logic                   host_tx_ready_i,
	input  wire logic                   rxd_pin_i,
	output logic                        rxd_o,
	input  wire logic                   txd_i,
	output logic                        txd_pin_o,
	input  wire logic                   owire_i,
	output logic                        owire_o,
	output logic                        owire_oe_o,
	input  wire logic                   bus_above_trip_i,
	output logic                        apu_o,
	output logic                        spu_o,
	output logic                        prog_o
);
	import oswb_pkg::*;

	function automatic logic addr_ok(input logic [APB_AW-1:0] a);
		addr_ok = (a == ADDR_CTRL) || (a == ADDR_STAT);
	endfunction

	oswb_stream_if #(.W(BYTE_W)) in_if ();
	oswb_stream_if #(.W(BYTE_W)) out_if ();

	oswb_state_e state_q;
	logic [31:0] tmr_q;
	logic        data_mode_q;
	logic        armed_q;
	logic        spu_timed_q;
	logic        pp_sel_q;
	logic        spu_sel_q;
	logic [7:0]  byte_q;
	logic [7:0]  rx_sh_q;
	logic [2:0]  bit_q;
	logic        samp_q;
	logic        pres_q;
	logic        drive_q;
	logic        drive_d;
	logic        resp_valid_q;
	logic [7:0]  resp_q;
	logic [2:0]  baud_q;
	logic        inv;
	logic        apu_q;
	logic [7:0]  apu_tmr_q;
	logic        rxd_q;
	logic        txd_q;
	logic [31:0] prdata_q;
	logic [7:0]  head;
	logic        take;
	logic        take_term;
	logic        slot_end;
	logic        rst_end;
	logic        prog_end;
	logic        spu_end;
	logic        cfg_hit;
	logic        ld_resp;
	logic [7:0]  ld_val;

	////////////////////////////////////////////////////////////////////////
	// host byte buffer
	assign in_if.valid     = host_rx_valid_i;
	assign in_if.data      = host_rx_data_i;
	assign host_rx_ready_o = in_if.ready;

	oswb_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.in_s      (in_if.snk),
		.out_s     (out_if.src)
	);

	assign head      = out_if.data;
	assign take      = (state_q == S_IDLE) && out_if.valid && !resp_valid_q;
	assign take_term = (state_q == S_SPU) && !spu_timed_q && out_if.valid
		&& (head == CMD_TERM) && !resp_valid_q;
	assign out_if.ready = take || take_term;

	////////////////////////////////////////////////////////////////////////
	// end-of-activity detection and responses
	assign slot_end = (state_q == S_SLOT) && (tmr_q == 32'(SLOT_CYC - 1)) && (bit_q == 3'h7);
	assign rst_end  = (state_q == S_RST) && (tmr_q == 32'(RST_END_P - 1));
	assign prog_end = (state_q == S_PROG) && (tmr_q == 32'(PP_P - 1));
	assign spu_end  = (state_q == S_SPU) && !resp_valid_q
		&& (spu_timed_q ? (tmr_q >= 32'(SPU_P - 1)) : take_term);
	assign cfg_hit  = take && !data_mode_q && ((head == CMD_PP_512) || (head == CMD_SPU_524));
	assign ld_resp  = slot_end || rst_end || prog_end || spu_end || cfg_hit;

	always_comb
	begin
		if (slot_end)
			ld_val = {samp_q, rx_sh_q[7:1]};
		else if (rst_end)
			ld_val = pres_q ? RSP_PRES : RSP_NOPRES;
		else if (prog_end)
			ld_val = RSP_PROG;
		else if (spu_end)
			ld_val = RSP_PULSE;
		else if (head == CMD_PP_512)
			ld_val = RSP_PP_512;
		else
			ld_val = RSP_SPU_524;
	end

	// a new answer wins over the host taking the old one
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			resp_valid_q <= 1'b0;
			resp_q       <= 8'h00;
		end
		else if (ld_resp)
		begin
			resp_valid_q <= 1'b1;
			resp_q       <= ld_val;
		end
		else if (host_tx_ready_i)
			resp_valid_q <= 1'b0;
	end

	assign host_tx_valid_o = resp_valid_q;
	assign host_tx_data_o  = resp_q;

	////////////////////////////////////////////////////////////////////////
	// command interpreter and bus engine
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			state_q     <= S_IDLE;
			tmr_q       <= '0;
			data_mode_q <= 1'b0;
			armed_q     <= 1'b0;
			spu_timed_q <= 1'b0;
			pp_sel_q    <= 1'b0;
			spu_sel_q   <= 1'b0;
			byte_q      <= 8'h00;
			rx_sh_q     <= 8'h00;
			bit_q       <= 3'h0;
			samp_q      <= 1'b0;
			pres_q      <= 1'b0;
		end
		else
		begin
			case (state_q)
				S_IDLE:
				begin
					tmr_q <= '0;
					if (take && data_mode_q)
					begin
						if (head == CMD_CMD_MODE)
							data_mode_q <= 1'b0;
						else
						begin
							byte_q  <= head;
							bit_q   <= 3'h0;
							state_q <= S_SLOT;
						end
					end
					else if (take)
					begin
						case (head)
							CMD_DATA_MODE: data_mode_q <= 1'b1;
							CMD_PP_512:    pp_sel_q <= 1'b1;
							CMD_SPU_524:   spu_sel_q <= 1'b1;
							CMD_RESET:     state_q <= S_RST;
							CMD_PROG:      state_q <= S_PROG;
							CMD_ARM:
							begin
								armed_q     <= 1'b1;
								spu_timed_q <= 1'b0;
								state_q     <= S_SPU;
							end
							CMD_DISARM:
							begin
								armed_q     <= 1'b0;
								spu_timed_q <= 1'b0;
								state_q     <= S_SPU;
							end
							default: ;
						endcase
					end
				end
				S_SLOT:
				begin
					if (tmr_q == 32'(SAMPLE_CYC))
						samp_q <= owire_i;
					if (tmr_q == 32'(SLOT_CYC - 1))
					begin
						tmr_q   <= '0;
						byte_q  <= {1'b0, byte_q[7:1]};
						rx_sh_q <= {samp_q, rx_sh_q[7:1]};
						bit_q   <= bit_q + 3'h1;
						if (bit_q == 3'h7)
						begin
							spu_timed_q <= 1'b1;
							state_q     <= armed_q ? S_SPU : S_IDLE;
						end
					end
					else
						tmr_q <= tmr_q + 32'h1;
				end
				S_RST:
				begin
					if (tmr_q == 32'(RST_SAMPLE_P))
						pres_q <= !owire_i;
					tmr_q <= tmr_q + 32'h1;
					if (rst_end)
						state_q <= S_IDLE;
				end
				S_PROG:
				begin
					tmr_q <= tmr_q + 32'h1;
					if (prog_end)
						state_q <= S_IDLE;
				end
				S_SPU:
				begin
					if (spu_end)
					begin
						tmr_q   <= '0;
						state_q <= S_IDLE;
					end
					else if (tmr_q < 32'(SPU_P - 1))
						tmr_q <= tmr_q + 32'h1;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus pins and active pullup
	always_comb
	begin
		drive_d = 1'b0;
		if (state_q == S_SLOT)
			drive_d = tmr_q < (byte_q[0] ? 32'(LOW1_CYC) : 32'(LOW0_CYC));
		else if (state_q == S_RST)
			drive_d = tmr_q < 32'(RST_LOW_P);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			drive_q <= 1'b0;
		else
			drive_q <= drive_d;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			apu_q     <= 1'b0;
			apu_tmr_q <= 8'h00;
		end
		else if (drive_q && !drive_d)
		begin
			apu_q     <= 1'b1;
			apu_tmr_q <= 8'h00;
		end
		else if (apu_q && (bus_above_trip_i || apu_tmr_q == 8'(APU_MAX_CYC - 1)))
			apu_q <= 1'b0;
		else if (apu_q)
			apu_tmr_q <= apu_tmr_q + 8'h01;
	end

	assign owire_o    = 1'b0;
	assign owire_oe_o = drive_q;
	assign apu_o      = apu_q;
	assign spu_o      = (state_q == S_SPU);
	assign prog_o     = (state_q == S_PROG);

	////////////////////////////////////////////////////////////////////////
	// serial polarity
	assign inv = (baud_q >= BAUD_INV_MIN);

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			rxd_q <= 1'b1;
			txd_q <= 1'b1;
		end
		else
		begin
			rxd_q <= rxd_pin_i ^ inv;
			txd_q <= txd_i ^ inv;
		end
	end

	assign rxd_o     = rxd_q;
	assign txd_pin_o = txd_q;

	////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, data latched in setup phase
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			baud_q <= BAUD_RST;
		else if (apb_psel_i && apb_penable_i && apb_pwrite_i && apb_paddr_i == ADDR_CTRL)
			baud_q <= apb_pwdata_i[2:0];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			prdata_q <= '0;
		else if (apb_psel_i && !apb_penable_i)
		begin
			if (apb_paddr_i == ADDR_CTRL)
				prdata_q <= {29'h0, baud_q};
			else if (apb_paddr_i == ADDR_STAT)
				prdata_q <= {19'h0, state_q, out_if.valid, resp_valid_q, pres_q,
					spu_sel_q, pp_sel_q, armed_q, data_mode_q, inv};
			else
				prdata_q <= '0;
		end
	end

	assign apb_prdata_o  = prdata_q;
	assign apb_pready_o  = 1'b1;
	assign apb_pslverr_o = apb_psel_i && apb_penable_i && !addr_ok(apb_paddr_i);

	////////////////////////////////////////////////////////////////////////
	// checks
	cfg_pp_resp_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		take && !data_mode_q && head == CMD_PP_512 |=> host_tx_valid_o && host_tx_data_o == RSP_PP_512)
		else $error("program pulse config not answered with 28");
	cfg_spu_resp_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		take && !data_mode_q && head == CMD_SPU_524 |=> host_tx_valid_o && host_tx_data_o == RSP_SPU_524)
		else $error("pullup config not answered with 38");
	armed_spu_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		slot_end && armed_q |=> spu_o && spu_timed_q && host_tx_valid_o)
		else $error("armed pullup did not follow data byte");
	pol_inv_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		baud_q >= BAUD_INV_MIN |=> txd_pin_o == !$past(txd_i) && rxd_o == !$past(rxd_pin_i))
		else $error("serial polarity not inverted");
	apu_on_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$fell(owire_oe_o) |-> apu_o)
		else $error("active pullup missing on rising edge");
	term_end_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		take_term |=> !spu_o ##0 host_tx_valid_o && host_tx_data_o == RSP_PULSE)
		else $error("termination did not end pullup with pulse response");
	buf_ready_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		state_q == S_SLOT && !out_if.valid |-> host_rx_ready_o)
		else $error("byte buffer refused while bus busy");
	mode_quiet_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		take && !resp_valid_q && (head == CMD_DATA_MODE || (data_mode_q && head == CMD_CMD_MODE))
		|=> !host_tx_valid_o)
		else $error("mode switch produced a response");
endmodule // oswb_bridge

// ---- oswb_bridge_tb.sv ----
// self-checking testbench of the serial single-wire bridge control block
`timescale 1ns/10ps
module oswb_bridge_tb;
	import oswb_pkg::*;
	localparam int PP_T     = 30;
	localparam int SPU_T    = 60;
	localparam int WAIT_MAX = 20000;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_valid = 1'b0;
	logic [7:0]  rx_data = 8'h00;
	logic        rx_ready;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_ready = 1'b0;
	logic        rxd_pin = 1'b1;
	logic        rxd;
	logic        txd = 1'b1;
	logic        txd_pin;
	logic        owire;
	logic        oe;
	logic        apu;
	logic        spu;
	logic        prog;
	logic        slv_pull;
	logic [7:0]  slv_val = 8'hFF;
	logic        slv_present = 1'b1;
	logic [31:0] rd;
	logic        err;
	logic        apu_seen = 1'b0;
	int          spu_c = 0;
	int          spu_last = 0;
	int          prog_c = 0;
	int          prog_last = 0;
	int          error_cnt = 0;
	int          samples_checked = 0;

	always #20 clk = ~clk;
	assign owire = ~(oe | slv_pull);

	oswb_bridge #(.RST_LOW_P(1600), .RST_SAMPLE_P(1650), .RST_END_P(1800), .PP_P(PP_T), .SPU_P(SPU_T)) DUT (
		.sys_clk_i(clk), .sys_rst_i(rst),
		.apb_psel_i(psel), .apb_penable_i(penable), .apb_pwrite_i(pwrite),
		.apb_paddr_i(paddr), .apb_pwdata_i(pwdata), .apb_prdata_o(prdata),
		.apb_pready_o(pready), .apb_pslverr_o(pslverr),
		.host_rx_valid_i(rx_valid), .host_rx_data_i(rx_data), .host_rx_ready_o(rx_ready),
		.host_tx_valid_o(tx_valid), .host_tx_data_o(tx_data), .host_tx_ready_i(tx_ready),
		.rxd_pin_i(rxd_pin), .rxd_o(rxd), .txd_i(txd), .txd_pin_o(txd_pin),
		.owire_i(owire), .owire_o(), .owire_oe_o(oe), .bus_above_trip_i(owire),
		.apu_o(apu), .spu_o(spu), .prog_o(prog)
	);

	oswb_slave_model SLV (
		.sys_clk_i(clk), .sys_rst_i(rst), .bus_i(owire),
		.val_i(slv_val), .present_i(slv_present), .pull_o(slv_pull)
	);

	////////////////////////////////////////////////////////////////////////
	// pulse length monitors
	always @(posedge clk)
	begin
		spu_c  <= (spu === 1'b1) ? spu_c + 1 : 0;
		prog_c <= (prog === 1'b1) ? prog_c + 1 : 0;
		if (spu !== 1'b1 && spu_c != 0)
			spu_last <= spu_c;
		if (prog !== 1'b1 && prog_c != 0)
			prog_last <= prog_c;
		if (apu === 1'b1)
			apu_seen <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic give_up();
		error_cnt++;
		$display("[FAIL] t=%0t wait bound used up", $time);
		report_and_stop();
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rdat, output logic rerr);
		logic rdy;
		int   n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			rdy = (pready === 1'b1);
			n++;
			if (n > 50)
				give_up();
		end
		while (!rdy);
		rdat    = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic send(input logic [7:0] b);
		logic rdy;
		int   n;
		n = 0;
		rx_valid <= 1'b1;
		rx_data  <= b;
		do
		begin
			@(posedge clk);
			rdy = (rx_ready === 1'b1);
			n++;
			if (n > WAIT_MAX)
				give_up();
		end
		while (!rdy);
		rx_valid <= 1'b0;
		@(posedge clk);
	endtask

	task automatic get(input logic [7:0] exp);
		int n;
		n = 0;
		tx_ready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (n > WAIT_MAX)
				give_up();
		end
		while (tx_valid !== 1'b1);
		check(tx_data, exp);
		tx_ready <= 1'b0;
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int n;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		check(rd, 32'h0);
		apb(1'b1, 12'h008, 32'h7, rd, err);
		check(err, 1'b1);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		check(rd, 32'h0);
		apb(1'b0, ADDR_STAT, 32'h0, rd, err);
		check(rd[12:8], 5'h01);
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, ADDR_CTRL, c, rd, err);
			apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
			check(rd[2:0], c[2:0]);
			rxd_pin <= 1'b0;
			txd     <= 1'b1;
			repeat (3) @(posedge clk);
			check(rxd, c >= 4);
			check(txd_pin, c < 4);
			rxd_pin <= 1'b1;
			txd     <= 1'b0;
			repeat (3) @(posedge clk);
			check(rxd, c < 4);
			check(txd_pin, c >= 4);
		end
		apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
		send(CMD_PP_512);
		get(RSP_PP_512);
		send(CMD_SPU_524);
		get(RSP_SPU_524);
		apb(1'b0, ADDR_STAT, 32'h0, rd, err);
		check(rd[4:3], 2'h3);
		slv_present <= 1'b0;
		send(CMD_RESET);
		get(RSP_NOPRES);
		slv_present <= 1'b1;
		send(CMD_RESET);
		get(RSP_PRES);
		// host stalls its receive side while the byte queue fills up
		n = 0;
		rx_valid <= 1'b1;
		rx_data  <= CMD_PP_512;
		do
		begin
			@(posedge clk);
			if (rx_ready !== 1'b1)
				break;
			n++;
		end
		while (n < 40);
		rx_valid <= 1'b0;
		check(n, FIFO_DEPTH + 2);
		repeat (FIFO_DEPTH + 2) get(RSP_PP_512);
		// eprom write loop with slave byte 3C
		slv_val <= 8'h3C;
		send(CMD_DATA_MODE);
		repeat (20) @(posedge clk);
		check(tx_valid, 1'b0);
		send(8'hA5);
		get(8'h24);
		send(8'hFF);
		send(8'hFF);
		get(8'h3C);
		get(8'h3C);
		send(CMD_CMD_MODE);
		send(CMD_PROG);
		get(RSP_PROG);
		check(prog_last, PP_T);
		send(CMD_DATA_MODE);
		send(8'hFF);
		get(8'h3C);
		check(apu_seen, 1'b1);
		// armed pullup for a conversion
		send(CMD_CMD_MODE);
		send(CMD_ARM);
		repeat (100) @(posedge clk);
		check(spu, 1'b1);
		check(tx_valid, 1'b0);
		send(CMD_TERM);
		get(RSP_PULSE);
		check(spu, 1'b0);
		send(CMD_DATA_MODE);
		send(8'h44);
		get(8'h04);
		get(RSP_PULSE);
		check(spu_last, SPU_T);
		send(CMD_CMD_MODE);
		send(CMD_DISARM);
		repeat (100) @(posedge clk);
		check(spu, 1'b1);
		send(CMD_TERM);
		get(RSP_PULSE);
		send(CMD_RESET);
		get(RSP_PRES);
		report_and_stop();
	end
endmodule // oswb_bridge_tb

// ---- oswb_fifo.sv ----
// host byte fifo with registered output stage
`timescale 1ns/10ps
module oswb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic      sys_clk_i,
	input  wire logic      sys_rst_i,
	oswb_stream_if.snk     in_s,
	oswb_stream_if.src     out_s
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0]   cnt_q;
	logic          ov_q;
	logic [W-1:0]  od_q;
	logic          push;
	logic          pop;

	assign in_s.ready  = (cnt_q != (PW+1)'(DEPTH));
	assign push        = in_s.valid && in_s.ready;
	assign pop         = (cnt_q != '0) && (!ov_q || out_s.ready);
	assign out_s.valid = ov_q;
	assign out_s.data  = od_q;

	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem_q[wr_q] <= in_s.data;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ov_q <= 1'b0;
			od_q <= '0;
		end
		else if (pop)
		begin
			ov_q <= 1'b1;
			od_q <= mem_q[rd_q];
		end
		else if (out_s.ready)
			ov_q <= 1'b0;
	end
endmodule // oswb_fifo

// ---- oswb_pkg.sv ----
// constants shared by the serial single-wire bridge control block
package oswb_pkg;

	localparam int CLK_MHZ      = 25;
	localparam int CLK_PERIOD_NS = 40;

	// bus timing in microseconds / milliseconds
	localparam int SLOT_US       = 70;
	localparam int LOW1_US       = 6;
	localparam int LOW0_US       = 60;
	localparam int SAMPLE_US     = 15;
	localparam int APU_MAX_US    = 2;
	localparam int RST_LOW_US    = 480;
	localparam int RST_SAMPLE_US = 550;
	localparam int RST_END_US    = 960;
	localparam int PP_512_US     = 512;
	localparam int SPU_524_MS    = 524;

	// same times in clock cycles
	localparam int SLOT_CYC       = SLOT_US * CLK_MHZ;
	localparam int LOW1_CYC       = LOW1_US * CLK_MHZ;
	localparam int LOW0_CYC       = LOW0_US * CLK_MHZ;
	localparam int SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
	localparam int APU_MAX_CYC    = APU_MAX_US * CLK_MHZ;
	localparam int RST_LOW_CYC    = RST_LOW_US * CLK_MHZ;
	localparam int RST_SAMPLE_CYC = RST_SAMPLE_US * CLK_MHZ;
	localparam int RST_END_CYC    = RST_END_US * CLK_MHZ;
	localparam int PP_CYC         = PP_512_US * CLK_MHZ;
	localparam int SPU_CYC        = SPU_524_MS * 1000 * CLK_MHZ;

	// host byte codes
	localparam logic [7:0] CMD_DATA_MODE = 8'hE1;
	localparam logic [7:0] CMD_CMD_MODE  = 8'hE3;
	localparam logic [7:0] CMD_PP_512    = 8'h29;
	localparam logic [7:0] RSP_PP_512    = 8'h28;
	localparam logic [7:0] CMD_SPU_524   = 8'h39;
	localparam logic [7:0] RSP_SPU_524   = 8'h38;
	localparam logic [7:0] CMD_ARM       = 8'hEF;
	localparam logic [7:0] CMD_DISARM    = 8'hED;
	localparam logic [7:0] CMD_TERM      = 8'hF1;
	localparam logic [7:0] CMD_PROG      = 8'hFD;
	localparam logic [7:0] CMD_RESET     = 8'hC1;
	localparam logic [7:0] RSP_PRES      = 8'hCD;
	localparam logic [7:0] RSP_NOPRES    = 8'hED;
	localparam logic [7:0] RSP_PULSE     = 8'hEC;
	localparam logic [7:0] RSP_PROG      = 8'hFC;

	// register map
	localparam int         APB_AW    = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [2:0] BAUD_RST  = 3'h0;
	localparam logic [2:0] BAUD_INV_MIN = 3'h4;

	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_SLOT = 5'b00010,
		S_RST  = 5'b00100,
		S_PROG = 5'b01000,
		S_SPU  = 5'b10000
	} oswb_state_e;

endpackage

// ---- oswb_slave_model.sv ----
// behavioural single-wire slave: presence pulse and read slots from a fixed byte
`timescale 1ns/10ps
module oswb_slave_model #(
	parameter int RST_MIN  = 1550,
	parameter int PRES_LEN = 100,
	parameter int BIT0_LEN = 1000
) (
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       bus_i,
	input  wire logic [7:0] val_i,
	input  wire logic       present_i,
	output logic            pull_o
);
	logic        prev_q;
	logic [11:0] low_q;
	logic [10:0] hold_q;
	logic [2:0]  idx_q;

	////////////////////////////////////////////////////////////////////////
	// a low of at least RST_MIN cycles is a bus reset; any falling edge while the slave is not holding the line starts a slot
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			prev_q <= 1'b1;
			low_q  <= '0;
			hold_q <= '0;
			idx_q  <= '0;
		end
		else
		begin
			prev_q <= bus_i;
			// count every low cycle, whoever pulls, so a held zero bit is never taken for a reset
			if (!bus_i)
				low_q <= low_q + 12'h001;
			else
				low_q <= '0;
			if (hold_q != 0)
				hold_q <= hold_q - 11'h001;
			if (bus_i && !prev_q && low_q >= 12'(RST_MIN))
			begin
				idx_q <= '0;
				if (present_i)
					hold_q <= 11'(PRES_LEN);
			end
			else if (!bus_i && prev_q && hold_q == 0)
			begin
				// a zero bit holds the line low past the master's sample point
				if (!val_i[idx_q])
					hold_q <= 11'(BIT0_LEN);
				idx_q <= idx_q + 3'h1;
			end
		end
	end

	assign pull_o = (hold_q != 0);
endmodule // oswb_slave_model

// ---- oswb_stream_if.sv ----
// byte stream carrier with valid and ready
`timescale 1ns/10ps
interface oswb_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
